/* File: serial_peer.sv */
// Purpose: remote serial device: sends frames on rxd, decodes frames on txd
// Assumes: 8 data bits, one start bit, least significant bit first
// Notes:   Line idles high between frames; errors only where a caller asks;
//          decoded frames are taken to carry one parity bit before the stop bit
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
   parameter int BIT_CYC = 8
) (
   // Clock
   input  wire logic       mclk_i,
   // Serial lines
   output logic            rxd_o,
   input  wire logic       txd_i
);
   logic [7:0] got;
   logic       got_stop;
   logic       got_par;
   int         got_n;
   initial begin
      rxd_o    = 1'b1;
      got      = 8'h00;
      got_par  = 1'b0;
      got_stop = 1'b0;
      got_n    = 0;
   end
   task automatic put_bit(input logic b);
      @(posedge mclk_i);
      rxd_o <= b;
      repeat (BIT_CYC - 1) @(posedge mclk_i);
   endtask
   // Parity and stop levels are the caller's, so bad frames can be made
   task automatic send(input logic [7:0] d, input logic pen, input logic pv, input logic sv);
      put_bit(1'b0);
      for (int i = 0; i < 8; i++) put_bit(d[i]);
      if (pen) put_bit(pv);
      put_bit(sv);
      put_bit(1'b1);
      put_bit(1'b1);
   endtask
   // Mid-bit sampling of whatever the block transmits
   always begin
      @(negedge txd_i);
      repeat (BIT_CYC / 2) @(posedge mclk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge mclk_i);
         got[i] = txd_i;
      end
      repeat (BIT_CYC) @(posedge mclk_i);
      got_par = txd_i;
      repeat (BIT_CYC) @(posedge mclk_i);
      got_stop = txd_i;
      got_n++;
   end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Purpose: self-checking bench for the status and flag registers
// Assumes: Wishbone answer one cycle after the taking edge
// Notes:   Short bit time keeps frames to about a hundred cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import uart_sf_pkg::*;
   localparam int BC = 8;
   typedef struct {logic [3:0] pins; logic [31:0] exp;} row_t;
   logic        mclk_i, rst_n_i, cyc_i, stb_i, we_i, rxd_i, txd_o, ack_o;
   logic [11:0] adr_i;
   logic [3:0]  sel_i, modem;
   logic [31:0] dat_i, dat_o, q;
   int          bad_count, compares;
   row_t        rows [4];
   logic [31:0] pops [4];
   uart_status_flags #(.BIT_CYC(BC), .DEPTH(32)) DUT (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .rxd_i(rxd_i), .txd_o(txd_o), .ring_in_n_i(modem[3]), .carrier_in_n_i(modem[2]),
      .set_ready_in_n_i(modem[1]), .clear_send_in_n_i(modem[0]));
   serial_peer #(.BIT_CYC(BC)) peer (.mclk_i(mclk_i), .rxd_o(rxd_i), .txd_i(txd_o));
   always #12.5 mclk_i = ~mclk_i;
   //---------------------------------------------------------------------------
   // Shared tasks
   //---------------------------------------------------------------------------
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
         bad_count++;
      end
   endtask
   // Request held until ack is seen; ack and data taken at the rising edge
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge mclk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      if (ack_o !== 1'b1) begin
         bad_count++;
         report_and_stop();
      end
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
   endtask
   //---------------------------------------------------------------------------
   // Main sequence
   //---------------------------------------------------------------------------
   initial begin
      mclk_i = 0; rst_n_i = 0; cyc_i = 0; stb_i = 0; we_i = 0;
      adr_i = 12'h000; sel_i = 4'hf; dat_i = 32'h0; modem = 4'hf;
      bad_count = 0; compares = 0;
      rows = '{'{4'hf, 32'h000}, '{4'h0, 32'h107}, '{4'h5, 32'h102}, '{4'ha, 32'h005}};
      pops = '{32'h25a, 32'h133, 32'h400, 32'h044};
      repeat (12) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      wb(0, FLAG_OFS, 0); chk(q, 32'h90, "flags at reset");
      wb(0, RSR_OFS, 0); chk(q, 32'h0, "status at reset");
      wb(0, 12'h100, 0); chk(q, 32'h0, "unmapped read");
      for (int i = 0; i < 4; i++) begin
         modem <= rows[i].pins;
         repeat (4) @(posedge mclk_i);
         wb(0, FLAG_OFS, 0); chk(q & 32'h107, rows[i].exp, "modem flags");
      end
      modem <= 4'hf;
      $display("reset and modem tests done");
      // Stick parity with even select: the parity bit sent must be zero
      wb(1, LCR_OFS, 32'he6);
      wb(1, DATA_OFS, 32'ha7);
      wb(0, FLAG_OFS, 0); chk(q & 32'ha8, 32'h28, "busy while disabled");
      wb(1, CTRL_OFS, 32'h301);
      for (int n = 0; n < 300 && q[BUSY_POS] !== 1'b0; n++) wb(0, FLAG_OFS, 0);
      if (q[BUSY_POS] !== 1'b0) begin
         bad_count++;
         report_and_stop();
      end
      chk(q & 32'ha8, 32'h80, "idle after send");
      chk({peer.got_stop, peer.got_par, peer.got_n[3:0], peer.got}, 14'h21a7, "tx");
      wb(1, LCR_OFS, 32'h60);
      $display("transmit test done");
      peer.send(8'h11, 0, 0, 1);
      wb(0, FLAG_OFS, 0); chk(q & 32'h50, 32'h40, "holding full");
      peer.send(8'h22, 0, 0, 1);
      wb(0, RSR_OFS, 0); chk(q, 32'h8, "overrun");
      wb(0, DATA_OFS, 0); chk(q & 32'h7ff, 32'h011, "first char kept");
      wb(0, FLAG_OFS, 0); chk(q & 32'h50, 32'h10, "holding empty");
      wb(1, RSR_OFS, 32'h0); wb(0, RSR_OFS, 0); chk(q, 32'h0, "clear");
      $display("overrun test done");
      // Stick parity with odd select: the parity bit must be one
      wb(1, LCR_OFS, 32'hf2);
      peer.send(8'h5a, 1, 0, 1);
      peer.send(8'h33, 1, 1, 0);
      peer.send(8'h00, 1, 0, 0);
      peer.send(8'h44, 1, 1, 1);
      for (int i = 0; i < 4; i++) begin
         wb(0, DATA_OFS, 0); chk(q, pops[i], "queued errors");
      end
      wb(0, RSR_OFS, 0); chk(q, 32'h7, "error status");
      wb(1, RSR_OFS, 32'hffff_ffff); wb(0, RSR_OFS, 0); chk(q, 32'h0, "clear all");
      $display("receive error test done");
      report_and_stop();
   end
endmodule
`default_nettype wire

/* File: uart_sf_pkg.sv */
//------------------------------------------------------------------------------
// Purpose: constants for the serial port status and flag block
// Assumes: 40 MHz mclk_i, byte addresses on a 32-bit Wishbone slave
// Notes:   bit positions are shared by the design and the bench
// Summary of operation
// - Overrun status bit 3 sets when a character arrives with receive queue full.
// - On overrun queue contents stay; the new character is dropped.
// - Break status bit 2 sets when line stays low a whole frame.
// - Break loads one zero character, then waits for idle line and start.
// - Parity status bit 1 sets on parity mismatch per even/stick settings, except in a break.
// - Framing status bit 0 sets when the stop bit reads zero, except in a break.
// - Any write to the status address clears all four error bits.
// - Break, parity, framing errors travel with their character through the queue.
// - Flag bit 8 is the inverse of the ring input.
// - Flag bit 2 is the inverse of the carrier input.
// - Flag bit 1 is the inverse of the set-ready input.
// - Flag bit 0 is the inverse of the clear-to-send input.
// - Flag bit 7 shows transmit queue empty, ignores shifter, resets one.
// - Flag bit 6 shows receive queue full, resets zero.
// - Flag bit 5 shows transmit queue full, resets zero.
// - Flag bit 4 shows receive queue empty, resets one.
// - Busy flag bit 3 holds until the last stop bit leaves.
// - Busy rises when transmit queue holds data, even when disabled.
// - With queues off, each queue is a one-byte holding register.
// - Stick parity sends and checks constant one if odd, zero if even.
//------------------------------------------------------------------------------
package uart_sf_pkg;
   // Register byte offsets
   localparam logic [11:0] DATA_OFS   = 12'h000;
   localparam logic [11:0] RSR_OFS    = 12'h004;
   localparam logic [11:0] FLAG_OFS   = 12'h018;
   localparam logic [11:0] LCR_OFS    = 12'h02c;
   localparam logic [11:0] CTRL_OFS   = 12'h030;
   // Status bit positions
   localparam int OE_POS      = 3;
   localparam int BRK_ERR_POS = 2;
   localparam int PAR_ERR_POS = 1;
   localparam int FRM_ERR_POS = 0;
   // Flag bit positions
   localparam int RI_POS       = 8;
   localparam int TX_EMPTY_POS = 7;
   localparam int RX_FULL_POS  = 6;
   localparam int TX_FULL_POS  = 5;
   localparam int RX_EMPTY_POS = 4;
   localparam int BUSY_POS = 3;
   localparam int DCD_POS  = 2;
   localparam int DSR_POS  = 1;
   localparam int CTS_POS  = 0;
   // Line control positions
   localparam int STICK_SEL_POS = 7;
   localparam int WLEN_LO       = 5;
   localparam int FIFO_ON_POS   = 4;
   localparam int STP2_POS      = 3;
   localparam int EVEN_SEL_POS  = 2;
   localparam int PEN_POS  = 1;
   // Control positions
   localparam int EN_POS  = 0;
   localparam int TXE_POS = 8;
   localparam int RXE_POS = 9;
   // Reset values
   localparam logic [3:0] RSR_RST  = 4'h0;
   localparam logic [7:0] LCR_RST  = 8'h00;
   localparam logic [2:0] CTRL_RST = 3'h6;
   // Bit timing
   localparam int CLK_HZ   = 40_000_000;
   localparam int BAUD_HZ  = 115_200;
   localparam int BIT_CLKS = CLK_HZ / BAUD_HZ;
   localparam int Q_DEPTH  = 32;

   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} rx_st_t;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_st_t;
endpackage

/* File: uart_status_flags.sv */
//------------------------------------------------------------------------------
// Purpose: receive error status, error clear and flag registers with the
//          receive and transmit paths that feed them
// Assumes: Wishbone classic slave, one wait state; DEPTH is a power of two
// Notes:   Modem and receive pins pass two flip-flops before use
//------------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module uart_status_flags
   import uart_sf_pkg::*;
#(
   parameter int BIT_CYC = BIT_CLKS,
   parameter int DEPTH   = Q_DEPTH
) (
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [11:0] adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // Serial line and modem status
   input  wire logic        rxd_i,
   output logic             txd_o,
   input  wire logic        ring_in_n_i,
   input  wire logic        carrier_in_n_i,
   input  wire logic        set_ready_in_n_i,
   input  wire logic        clear_send_in_n_i
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = PW + 1;
   localparam int BW = $clog2(BIT_CYC + 1);

   function automatic logic par_fn(input logic [7:0] d, input logic [1:0] wl,
                                   input logic even_sel, input logic stick_sel);
      logic [7:0] m;
      m = 8'h1f;
      // Five data bits always count; each word length step adds one more
      for (int i = 5; i < 8; i++) begin
         if (i - 5 < int'(wl)) begin
            m[i] = 1'b1;
         end
      end
      if (stick_sel) begin
         par_fn = ~even_sel;
      end else begin
         par_fn = even_sel ? ^(d & m) : ~^(d & m);
      end
   endfunction

   //---------------------------------------------------------------------------
   // Synchronisers
   //---------------------------------------------------------------------------
   logic [4:0] sy1_ff;
   logic [4:0] sy2_ff;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         sy1_ff <= 5'h1f;
         sy2_ff <= 5'h1f;
      end else begin
         sy1_ff <= {rxd_i, ring_in_n_i, carrier_in_n_i, set_ready_in_n_i, clear_send_in_n_i};
         sy2_ff <= sy1_ff;
      end
   end
   logic rxd;
   assign rxd = sy2_ff[4];

   //---------------------------------------------------------------------------
   // Bus decode and control registers
   //---------------------------------------------------------------------------
   logic       ack_ff;
   logic       hit;
   logic       wr_dr, rd_dr, wr_rsr;
   logic [7:0] lcr_ff;
   logic [2:0] ctrl_ff;
   logic       fifo_on;
   assign hit    = cyc_i && stb_i && !ack_ff;
   assign wr_dr  = hit && we_i && adr_i == DATA_OFS && sel_i[0];
   assign rd_dr  = hit && !we_i && adr_i == DATA_OFS;
   assign wr_rsr = hit && we_i && adr_i == RSR_OFS;
   assign fifo_on = lcr_ff[FIFO_ON_POS];

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         lcr_ff  <= LCR_RST;
         ctrl_ff <= CTRL_RST;
      end else if (hit && we_i && sel_i[0] && adr_i == LCR_OFS) begin
         lcr_ff <= dat_i[7:0];
      end else if (hit && we_i && adr_i == CTRL_OFS) begin
         if (sel_i[0]) begin
            ctrl_ff[0] <= dat_i[EN_POS];
         end
         if (sel_i[1]) begin
            ctrl_ff[2:1] <= {dat_i[RXE_POS], dat_i[TXE_POS]};
         end
      end
   end

   //---------------------------------------------------------------------------
   // Receive queue: data plus break, parity, framing per entry
   //---------------------------------------------------------------------------
   logic [10:0]   rq_mem [DEPTH];
   logic [PW-1:0] rq_wp_ff, rq_rp_ff;
   logic [CW-1:0] rq_cnt_ff;
   logic          rq_full, rq_empty, rx_push, rq_wr, rq_pop;
   logic [10:0]   rx_word;
   // Queues off shrink to one entry
   assign rq_full  = fifo_on ? rq_cnt_ff == CW'(DEPTH) : rq_cnt_ff != '0;
   assign rq_empty = rq_cnt_ff == '0;
   assign rq_wr    = rx_push && !rq_full;
   assign rq_pop   = rd_dr && !rq_empty;

   always_ff @(posedge mclk_i) begin
      if (rq_wr) begin
         rq_mem[rq_wp_ff] <= rx_word;
      end
   end
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rq_wp_ff  <= '0;
         rq_rp_ff  <= '0;
         rq_cnt_ff <= '0;
      end else begin
         rq_wp_ff  <= rq_wp_ff + PW'(rq_wr);
         rq_rp_ff  <= rq_rp_ff + PW'(rq_pop);
         rq_cnt_ff <= rq_cnt_ff + CW'(rq_wr) - CW'(rq_pop);
      end
   end

   //---------------------------------------------------------------------------
   // Transmit queue
   //---------------------------------------------------------------------------
   logic [7:0]    tq_mem [DEPTH];
   logic [PW-1:0] tq_wp_ff, tq_rp_ff;
   logic [CW-1:0] tq_cnt_ff;
   logic          tq_full, tq_empty, tq_wr, tq_pop;
   assign tq_full  = fifo_on ? tq_cnt_ff == CW'(DEPTH) : tq_cnt_ff != '0;
   assign tq_empty = tq_cnt_ff == '0;
   assign tq_wr    = wr_dr && !tq_full;

   always_ff @(posedge mclk_i) begin
      if (tq_wr) begin
         tq_mem[tq_wp_ff] <= dat_i[7:0];
      end
   end
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         tq_wp_ff  <= '0;
         tq_rp_ff  <= '0;
         tq_cnt_ff <= '0;
      end else begin
         tq_wp_ff  <= tq_wp_ff + PW'(tq_wr);
         tq_rp_ff  <= tq_rp_ff + PW'(tq_pop);
         tq_cnt_ff <= tq_cnt_ff + CW'(tq_wr) - CW'(tq_pop);
      end
   end

   //---------------------------------------------------------------------------
   // Receiver
   //---------------------------------------------------------------------------
   rx_st_t        rx_st_ff;
   logic [BW-1:0] rx_cnt_ff;
   logic [2:0]    rx_idx_ff;
   logic [7:0]    rx_sh_ff;
   logic          rx_zero_ff, rx_par_err_ff, rx_tick, rx_brk;
   assign rx_tick = rx_cnt_ff == '0;
   assign rx_push = rx_st_ff == RX_STOP && rx_tick;
   // Low through start, data, parity and stop is a break
   assign rx_brk  = rx_zero_ff && !rxd;
   assign rx_word = rx_brk ? 11'h400 : {1'b0, rx_par_err_ff, !rxd, rx_sh_ff};

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rx_st_ff   <= RX_IDLE;
         rx_cnt_ff  <= '0;
         rx_idx_ff  <= '0;
         rx_sh_ff   <= '0;
         rx_zero_ff <= 1'b0;
         rx_par_err_ff <= 1'b0;
      end else begin
         if (!rx_tick) begin
            rx_cnt_ff <= rx_cnt_ff - 1'b1;
         end
         case (rx_st_ff)
            RX_IDLE: begin
               if (!rxd && ctrl_ff[0] && ctrl_ff[2]) begin
                  rx_st_ff   <= RX_START;
                  rx_cnt_ff  <= BW'(BIT_CYC / 2);
                  rx_sh_ff   <= '0;
                  rx_idx_ff  <= '0;
                  rx_zero_ff <= 1'b1;
                  rx_par_err_ff <= 1'b0;
               end
            end
            RX_START: begin
               if (rx_tick) begin
                  // A glitch shorter than half a bit is no start
                  rx_st_ff  <= rxd ? RX_IDLE : RX_DATA;
                  rx_cnt_ff <= BW'(BIT_CYC - 1);
               end
            end
            RX_DATA: begin
               if (rx_tick) begin
                  rx_sh_ff[rx_idx_ff] <= rxd;
                  rx_zero_ff <= rx_zero_ff && !rxd;
                  rx_idx_ff  <= rx_idx_ff + 1'b1;
                  rx_cnt_ff  <= BW'(BIT_CYC - 1);
                  if (rx_idx_ff == 3'd4 + {1'b0, lcr_ff[6:5]}) begin
                     rx_st_ff <= lcr_ff[PEN_POS] ? RX_PAR : RX_STOP;
                  end
               end
            end
            RX_PAR: begin
               if (rx_tick) begin
                  rx_par_err_ff <= rxd != par_fn(rx_sh_ff, lcr_ff[6:5], lcr_ff[EVEN_SEL_POS],
                                                 lcr_ff[STICK_SEL_POS]);
                  rx_zero_ff <= rx_zero_ff && !rxd;
                  rx_cnt_ff  <= BW'(BIT_CYC - 1);
                  rx_st_ff   <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (rx_tick) begin
                  rx_st_ff <= rx_brk ? RX_BRK : RX_IDLE;
               end
            end
            default: begin
               // Hold off until the line marks again
               if (rxd) begin
                  rx_st_ff <= RX_IDLE;
               end
            end
         endcase
      end
   end

   //---------------------------------------------------------------------------
   // Transmitter
   //---------------------------------------------------------------------------
   tx_st_t        tx_st_ff;
   logic [BW-1:0] tx_cnt_ff;
   logic [2:0]    tx_idx_ff;
   logic [7:0]    tx_sh_ff;
   logic          tx_stp_ff, txd_ff, tx_tick;
   assign tx_tick = tx_cnt_ff == '0;
   assign tq_pop  = tx_st_ff == TX_IDLE && !tq_empty && ctrl_ff[0] && ctrl_ff[1];

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         tx_st_ff  <= TX_IDLE;
         tx_cnt_ff <= '0;
         tx_idx_ff <= '0;
         tx_sh_ff  <= '0;
         tx_stp_ff <= 1'b0;
         txd_ff    <= 1'b1;
      end else begin
         if (!tx_tick) begin
            tx_cnt_ff <= tx_cnt_ff - 1'b1;
         end
         case (tx_st_ff)
            TX_IDLE: begin
               if (tq_pop) begin
                  tx_sh_ff  <= tq_mem[tq_rp_ff];
                  tx_st_ff  <= TX_START;
                  tx_cnt_ff <= BW'(BIT_CYC - 1);
                  tx_idx_ff <= '0;
                  txd_ff    <= 1'b0;
               end
            end
            TX_START, TX_DATA: begin
               if (tx_tick) begin
                  tx_cnt_ff <= BW'(BIT_CYC - 1);
                  if (tx_st_ff == TX_DATA &&
                      tx_idx_ff == 3'd5 + {1'b0, lcr_ff[6:5]}) begin
                     tx_st_ff <= lcr_ff[PEN_POS] ? TX_PAR : TX_STOP;
                     txd_ff   <= lcr_ff[PEN_POS] ? par_fn(tx_sh_ff, lcr_ff[6:5],
                                 lcr_ff[EVEN_SEL_POS], lcr_ff[STICK_SEL_POS]) : 1'b1;
                     tx_stp_ff <= lcr_ff[STP2_POS];
                  end else begin
                     tx_st_ff  <= TX_DATA;
                     txd_ff    <= tx_sh_ff[tx_idx_ff];
                     tx_idx_ff <= tx_idx_ff + 1'b1;
                  end
               end
            end
            TX_PAR: begin
               if (tx_tick) begin
                  tx_cnt_ff <= BW'(BIT_CYC - 1);
                  tx_st_ff  <= TX_STOP;
                  txd_ff    <= 1'b1;
               end
            end
            default: begin
               if (tx_tick) begin
                  tx_cnt_ff <= BW'(BIT_CYC - 1);
                  tx_stp_ff <= 1'b0;
                  if (!tx_stp_ff) begin
                     tx_st_ff <= TX_IDLE;
                  end
               end
            end
         endcase
      end
   end

   //---------------------------------------------------------------------------
   // Error status
   //---------------------------------------------------------------------------
   logic [3:0]  rsr_ff;
   logic [10:0] rq_head;
   assign rq_head = rq_empty ? 11'h000 : rq_mem[rq_rp_ff];

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rsr_ff <= RSR_RST;
      end else begin
         // A set in the clearing cycle survives
         rsr_ff[OE_POS] <= (rsr_ff[OE_POS] && !wr_rsr) || (rx_push && rq_full);
         for (int i = 0; i < 3; i++) begin
            rsr_ff[i] <= (rsr_ff[i] && !wr_rsr) || (rq_pop && rq_head[8+i]);
         end
      end
   end

   //---------------------------------------------------------------------------
   // Flags and read data
   //---------------------------------------------------------------------------
   logic [8:0]  flags;
   logic        busy;
   logic [31:0] rd_data;
   assign busy = !tq_empty || tx_st_ff != TX_IDLE;
   always_comb begin
      flags           = '0;
      flags[RI_POS]   = !sy2_ff[3];
      flags[TX_EMPTY_POS] = tq_empty;
      flags[RX_FULL_POS]  = rq_full;
      flags[TX_FULL_POS]  = tq_full;
      flags[RX_EMPTY_POS] = rq_empty;
      flags[BUSY_POS] = busy;
      flags[DCD_POS]  = !sy2_ff[2];
      flags[DSR_POS]  = !sy2_ff[1];
      flags[CTS_POS]  = !sy2_ff[0];
   end

   always_comb begin
      rd_data = '0;
      if (adr_i == DATA_OFS) begin
         rd_data[11:0] = {rsr_ff[OE_POS], rq_head};
      end else if (adr_i == RSR_OFS) begin
         rd_data[3:0] = rsr_ff;
      end else if (adr_i == FLAG_OFS) begin
         rd_data[8:0] = flags;
      end else if (adr_i == LCR_OFS) begin
         rd_data[7:0] = lcr_ff;
      end else if (adr_i == CTRL_OFS) begin
         rd_data[RXE_POS] = ctrl_ff[2];
         rd_data[TXE_POS] = ctrl_ff[1];
         rd_data[EN_POS]  = ctrl_ff[0];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         ack_ff <= 1'b0;
         dat_o  <= '0;
      end else begin
         ack_ff <= hit;
         if (hit && !we_i) begin
            dat_o <= rd_data;
         end
      end
   end
   assign ack_o = ack_ff;
   assign txd_o = txd_ff;

   //---------------------------------------------------------------------------
   // Assertions
   //---------------------------------------------------------------------------
   sequence s_rsr_clear;
      wr_rsr && !rx_push && !rq_pop;
   endsequence
   sequence s_overrun;
      rx_push && rq_full && !rq_pop;
   endsequence

   a_overrun_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      s_overrun |=> rsr_ff[OE_POS]) else $error("overrun not flagged");
   a_overrun_keep: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      s_overrun |=> rq_cnt_ff == $past(rq_cnt_ff)) else $error("overrun changed queue");
   a_break_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      rx_push && rx_brk |-> rx_word == 11'h400 ##1 rx_st_ff == RX_BRK)
      else $error("break not loaded as one zero character");
   a_err_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      s_rsr_clear |=> rsr_ff == 4'h0) else $error("error clear failed");
   a_modem_inv: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      ##3 flags[RI_POS] == !$past(ring_in_n_i, 2) &&
          flags[CTS_POS] == !$past(clear_send_in_n_i, 2))
      else $error("modem flag not inverted input");
   a_flag_reset: assert property (@(posedge mclk_i)
      $rose(rst_n_i) |-> flags[TX_EMPTY_POS] && flags[RX_EMPTY_POS] &&
                         !flags[RX_FULL_POS] && !flags[TX_FULL_POS])
      else $error("flag reset values wrong");
   a_busy_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      tx_st_ff == TX_STOP |-> flags[BUSY_POS]) else $error("busy dropped before stop bit");
   a_busy_queue: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      tq_wr |=> flags[BUSY_POS]) else $error("busy not raised by queued data");
   a_char_mode: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      !fifo_on && rq_cnt_ff == CW'(1) |-> flags[RX_FULL_POS])
      else $error("holding register not full");
   a_stick_par: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      $rose(tx_st_ff == TX_PAR) && lcr_ff[STICK_SEL_POS] |-> txd_ff == !lcr_ff[EVEN_SEL_POS])
      else $error("stick parity level wrong");
endmodule
`default_nettype wire
